/* design/acb_baud_gen.sv */
/*
  Baud divider: counts system clocks and gives a one-cycle tick at sixteen
  times the bit rate. Assumes the divider value comes from a register.
*/
`timescale 1ns/10ps
`default_nettype none
module acb_baud_gen import acb_pkg::*; #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // divider value and tick
  input wire logic [WIDTH-1:0] divider,
  output logic tick
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic tick;
  } acb_baud_state_t;

  acb_baud_state_t st;
  acb_baud_state_t next_st;

  // ==========================================================
  // count down, reload at zero; period is divider plus one
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == '0) begin
      next_st.cnt = divider;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  // ==========================================================
  // tick always comes with a fresh reload of the divider
  property p_reload;
    @(posedge clk_sys) disable iff (!arst_n)
      st.tick |-> st.cnt == $past(divider);
  endproperty
  a_reload: assert property (p_reload) else $error("tick without reload");

  // a nonzero divider leaves a gap after each tick
  property p_gap;
    @(posedge clk_sys) disable iff (!arst_n)
      st.tick && st.cnt != '0 |=> !st.tick;
  endproperty
  a_gap: assert property (p_gap) else $error("ticks too close");
endmodule
`default_nettype wire

/* design/acb_pkg.sv */
/*
  Constants shared by the serial control and baud block: register offsets,
  field positions, reset values, sampling points, frame lengths and states.
  Assumes an 8-bit register port and one system clock.
*/
// How it works
// - new character while holding full flags overrun
// - overrun shows when held character is read
// - successful transfer to holding clears overrun, unless a read reveals one in that cycle
// - status bits 2..0 read as zero
// - control bit 7 gates receive-done interrupt
// - control bit 6 gates transmit-done interrupt
// - control bit 5 gates holding-empty interrupt
// - receiver disabled blocks tx-done, overrun, framing flags
// - disabling receiver leaves those flags unchanged
// - transmitter drains shift and holding before stopping
// - control bit 2 selects nine data bits
// - control bit 1 shows received ninth bit
// - control bit 0 supplies transmitted ninth bit
// - bit rate is clock over 16(divider+1)
// - divider is 8-bit read/write register
// - receiver oversamples 16x, majority of samples 8-10
// - transmit start zero, data LSB first, stop one
// - framing error follows sampled stop bit
// - reading holding register clears receive-done
package acb_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ACB_OFF_BAUD = 8'h09;
  localparam logic [7:0] ACB_OFF_CTRL = 8'h0A;
  localparam logic [7:0] ACB_OFF_STAT = 8'h0B;
  localparam logic [7:0] ACB_OFF_DATA = 8'h0C;
  // ==========================================================
  // control field positions
  localparam int ACB_CTRL_RX_IE = 7;
  localparam int ACB_CTRL_TX_IE = 6;
  localparam int ACB_CTRL_EMPTY_IE = 5;
  localparam int ACB_CTRL_RX_EN = 4;
  localparam int ACB_CTRL_TX_EN = 3;
  localparam int ACB_CTRL_NINE = 2;
  localparam int ACB_CTRL_RX_NINTH = 1;
  localparam int ACB_CTRL_TX_NINTH = 0;
  // status field positions
  localparam int ACB_STAT_RXC = 7;
  localparam int ACB_STAT_TXC = 6;
  // ==========================================================
  // reset values
  localparam logic [7:0] ACB_CTRL_RST = 8'h00;
  localparam logic [7:0] ACB_STAT_RST = 8'h20;
  localparam logic [7:0] ACB_BAUD_RST = 8'h00;
  // ==========================================================
  // sampling and framing
  localparam logic [3:0] ACB_TICK_LAST = 4'hF;
  localparam logic [3:0] ACB_SAMPLE_A = 4'h8;
  localparam logic [3:0] ACB_SAMPLE_B = 4'h9;
  localparam logic [3:0] ACB_SAMPLE_C = 4'hA;
  localparam logic [3:0] ACB_FRAME_8 = 4'hA;
  localparam logic [3:0] ACB_FRAME_9 = 4'hB;
  localparam logic [3:0] ACB_STOP_IDX_8 = 4'h9;
  localparam logic [3:0] ACB_STOP_IDX_9 = 4'hA;
  // ==========================================================
  // states
  typedef enum logic {ACB_TX_IDLE, ACB_TX_BUSY} acb_tx_state_t;
  typedef enum logic {ACB_RX_IDLE, ACB_RX_BUSY} acb_rx_state_t;
endpackage

/* design/acb_serial.sv */
/*
  Serial control, status and baud block: register port, transmitter with
  holding and shift register, 16x oversampling receiver with overrun and
  framing checks, and interrupt requests. Assumes the receive line is
  already synchronous to clk_sys and that the core supplies the global
  interrupt enable and the transmit-done acknowledge.
*/
`timescale 1ns/10ps
`default_nettype none
module acb_serial import acb_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // core side
  input wire logic global_irq_enable,
  input wire logic tx_done_ack,
  output logic irq_rx_done,
  output logic irq_tx_done,
  output logic irq_tx_empty,
  // serial lines
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_line_oe
);
  typedef struct packed {
    logic rx_done_irq_enable;
    logic tx_done_irq_enable;
    logic tx_empty_irq_enable;
    logic receiver_enable;
    logic transmitter_enable;
    logic nine_bit_mode;
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic [7:0] baud_divider;
    logic [7:0] rdata;
    logic rx_done_flag;
    logic tx_done_flag;
    logic tx_holding_empty_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic overrun_pending;
    logic [7:0] rx_holding;
    logic [7:0] tx_holding;
    acb_tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_tick;
    acb_rx_state_t rx_state;
    logic [3:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [1:0] rx_votes;
    logic [8:0] rx_shift;
  } acb_ctl_state_t;

  acb_ctl_state_t st;
  acb_ctl_state_t next_st;
  logic tick;
  logic rd_data;
  logic wr_data;
  logic xfer;
  logic rx_stop;
  logic tx_load;
  logic frame_end;
  logic majority;
  logic [3:0] stop_idx;

  // ==========================================================
  // oversampling tick
  acb_baud_gen #(
    .WIDTH(8)
  ) u_baud (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .divider(st.baud_divider),
    .tick(tick)
  );

  assign rd_data = rd_en && (addr == ACB_OFF_DATA);
  assign wr_data = wr_en && (addr == ACB_OFF_DATA);
  // vote of samples 8 and 9 with the current sample 10
  assign majority = (st.rx_votes[0] & st.rx_votes[1]) | (st.rx_votes[0] & rx_line) |
                    (st.rx_votes[1] & rx_line);
  assign stop_idx = st.nine_bit_mode ? ACB_STOP_IDX_9 : ACB_STOP_IDX_8;

  // ==========================================================
  // next state; later sections win, so hardware sets beat software clears, but a data write beats the holding-empty set on load
  always_comb begin
    next_st = st;
    xfer = 1'b0;
    rx_stop = 1'b0;
    tx_load = 1'b0;
    frame_end = 1'b0;
    // register writes
    if (wr_en) begin
      case (addr)
        ACB_OFF_CTRL: begin
          next_st.rx_done_irq_enable = wdata[ACB_CTRL_RX_IE];
          next_st.tx_done_irq_enable = wdata[ACB_CTRL_TX_IE];
          next_st.tx_empty_irq_enable = wdata[ACB_CTRL_EMPTY_IE];
          next_st.receiver_enable = wdata[ACB_CTRL_RX_EN];
          next_st.transmitter_enable = wdata[ACB_CTRL_TX_EN];
          next_st.nine_bit_mode = wdata[ACB_CTRL_NINE];
          next_st.tx_ninth_bit = wdata[ACB_CTRL_TX_NINTH];
        end
        ACB_OFF_STAT: begin
          if (wdata[ACB_STAT_TXC]) begin
            next_st.tx_done_flag = 1'b0;
          end
        end
        ACB_OFF_BAUD: begin
          next_st.baud_divider = wdata;
        end
        default: begin
        end
      endcase
    end
    if (tx_done_ack) begin
      next_st.tx_done_flag = 1'b0;
    end
    // read data stand for one cycle only
    next_st.rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        ACB_OFF_CTRL: next_st.rdata = {st.rx_done_irq_enable, st.tx_done_irq_enable,
                                       st.tx_empty_irq_enable, st.receiver_enable,
                                       st.transmitter_enable, st.nine_bit_mode,
                                       st.rx_ninth_bit, 1'b0};
        ACB_OFF_STAT: next_st.rdata = {st.rx_done_flag, st.tx_done_flag,
                                       st.tx_holding_empty_flag, st.framing_error_flag,
                                       st.overrun_flag, 3'h0};
        ACB_OFF_BAUD: next_st.rdata = st.baud_divider;
        ACB_OFF_DATA: next_st.rdata = st.rx_holding;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // reading the held character releases it and reveals a buffered overrun
    if (rd_data) begin
      next_st.rx_done_flag = 1'b0;
      next_st.overrun_flag = st.overrun_pending;
      next_st.overrun_pending = 1'b0;
    end
    // transmitter: a frame in flight is never cut short by the enable
    case (st.tx_state)
      ACB_TX_IDLE: begin
        tx_load = !st.tx_holding_empty_flag && st.transmitter_enable;
      end
      ACB_TX_BUSY: begin
        if (tick) begin
          next_st.tx_tick = st.tx_tick + 4'h1;
          if (st.tx_tick == ACB_TICK_LAST) begin
            next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
            next_st.tx_bits = st.tx_bits - 4'h1;
            if (st.tx_bits == 4'h1) begin
              frame_end = 1'b1;
              if (!st.tx_holding_empty_flag) begin
                tx_load = 1'b1;
              end else begin
                next_st.tx_state = ACB_TX_IDLE;
                if (st.receiver_enable) begin
                  next_st.tx_done_flag = 1'b1;
                end
              end
            end
          end
        end
      end
      default: next_st.tx_state = ACB_TX_IDLE;
    endcase
    if (tx_load) begin
      next_st.tx_state = ACB_TX_BUSY;
      next_st.tx_tick = 4'h0;
      next_st.tx_holding_empty_flag = 1'b1;
      if (st.nine_bit_mode) begin
        next_st.tx_shift = {1'b1, st.tx_ninth_bit, st.tx_holding, 1'b0};
        next_st.tx_bits = ACB_FRAME_9;
      end else begin
        next_st.tx_shift = {2'b11, st.tx_holding, 1'b0};
        next_st.tx_bits = ACB_FRAME_8;
      end
    end
    // a write in the load cycle refills the holding register at once
    if (wr_data) begin
      next_st.tx_holding = wdata;
      next_st.tx_holding_empty_flag = 1'b0;
    end
    // receiver
    case (st.rx_state)
      ACB_RX_IDLE: begin
        // one zero sample on an idle line counts as sample 0 of a start bit
        if (st.receiver_enable && tick && !rx_line) begin
          next_st.rx_state = ACB_RX_BUSY;
          next_st.rx_cnt = 4'h1;
          next_st.rx_idx = 4'h0;
        end
      end
      ACB_RX_BUSY: begin
        if (!st.receiver_enable) begin
          next_st.rx_state = ACB_RX_IDLE;
        end else if (tick) begin
          next_st.rx_cnt = st.rx_cnt + 4'h1;
          if (st.rx_cnt == ACB_SAMPLE_A) begin
            next_st.rx_votes[0] = rx_line;
          end
          if (st.rx_cnt == ACB_SAMPLE_B) begin
            next_st.rx_votes[1] = rx_line;
          end
          if (st.rx_cnt == ACB_SAMPLE_C) begin
            next_st.rx_idx = st.rx_idx + 4'h1;
            if (st.rx_idx == 4'h0) begin
              // a start bit that votes high was a spike
              if (majority) begin
                next_st.rx_state = ACB_RX_IDLE;
              end
            end else if (st.rx_idx == stop_idx) begin
              rx_stop = 1'b1;
              next_st.rx_state = ACB_RX_IDLE;
            end else begin
              next_st.rx_shift = {majority, st.rx_shift[8:1]};
            end
          end
        end
      end
      default: next_st.rx_state = ACB_RX_IDLE;
    endcase
    // deliver, or lose the new character if the held one is unread
    if (rx_stop) begin
      if (st.rx_done_flag && !rd_data) begin
        next_st.overrun_pending = 1'b1;
      end else begin
        xfer = 1'b1;
        next_st.rx_holding = st.nine_bit_mode ? st.rx_shift[7:0] : st.rx_shift[8:1];
        if (st.nine_bit_mode) begin
          next_st.rx_ninth_bit = st.rx_shift[8];
        end
        next_st.rx_done_flag = 1'b1;
        next_st.framing_error_flag = !majority;
        // an overrun revealed in this same cycle is kept
        next_st.overrun_flag = rd_data ? st.overrun_pending : 1'b0;
      end
    end
  end

  // ==========================================================
  // state register; line idles high through the all-ones shift value
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.tx_holding_empty_flag <= ACB_STAT_RST[5];
      st.baud_divider <= ACB_BAUD_RST;
      st.tx_shift <= 11'h7FF;
      st.rx_votes <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign rdata = st.rdata;
  assign tx_line = st.tx_shift[0];
  assign tx_line_oe = st.transmitter_enable || (st.tx_state == ACB_TX_BUSY);
  assign irq_rx_done = global_irq_enable && st.rx_done_irq_enable && st.rx_done_flag;
  assign irq_tx_done = global_irq_enable && st.tx_done_irq_enable && st.tx_done_flag;
  assign irq_tx_empty = global_irq_enable && st.tx_empty_irq_enable &&
                        st.tx_holding_empty_flag;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_load;
    tx_load;
  endsequence
  sequence s_lost;
    rx_stop && st.rx_done_flag && !rd_data;
  endsequence

  property p_overrun_set;
    s_lost |=> st.overrun_pending && st.rx_done_flag && st.rx_holding == $past(st.rx_holding);
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not held");

  property p_overrun_shown;
    rd_data && st.overrun_pending && !xfer |=> st.overrun_flag && !st.overrun_pending;
  endproperty
  a_overrun_shown: assert property (p_overrun_shown) else $error("overrun not shown");

  property p_overrun_clear;
    xfer && !rd_data |=> !st.overrun_flag && st.rx_done_flag;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept");

  property p_status_low;
    rd_en && addr == ACB_OFF_STAT |=> rdata[2:0] == 3'h0;
  endproperty
  a_status_low: assert property (p_status_low) else $error("reserved bits set");

  property p_irq_rx;
    $rose(st.rx_done_flag) && st.rx_done_irq_enable && global_irq_enable |-> irq_rx_done;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("no rx interrupt");

  property p_irq_tx;
    $rose(st.tx_done_flag) && st.tx_done_irq_enable && global_irq_enable |-> irq_tx_done;
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("no tx interrupt");

  property p_irq_empty;
    s_load ##0 (st.tx_empty_irq_enable && !wr_data && !wr_en) ##1 global_irq_enable
      |-> irq_tx_empty;
  endproperty
  a_irq_empty: assert property (p_irq_empty) else $error("no empty interrupt");

  property p_rx_off_gate;
    !st.receiver_enable && !st.tx_done_flag |=> !st.tx_done_flag && !xfer;
  endproperty
  a_rx_off_gate: assert property (p_rx_off_gate) else $error("flag set while off");

  property p_rx_off_keep;
    st.framing_error_flag && !xfer |=> st.framing_error_flag;
  endproperty
  a_rx_off_keep: assert property (p_rx_off_keep) else $error("framing flag lost");

  property p_drain;
    frame_end && !st.tx_holding_empty_flag |=> st.tx_state == ACB_TX_BUSY && !tx_line;
  endproperty
  a_drain: assert property (p_drain) else $error("pending character dropped");

  property p_start_bit;
    s_load |=> !tx_line && tx_line_oe;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");

  property p_ninth;
    xfer && st.nine_bit_mode |=> st.rx_ninth_bit == $past(st.rx_shift[8]);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

  property p_rxc_clear;
    rd_data && !xfer |=> !st.rx_done_flag;
  endproperty
  a_rxc_clear: assert property (p_rxc_clear) else $error("receive flag kept");
endmodule
`default_nettype wire

/* dv/acb_remote_peer.sv */
/*
  Remote serial peer: sends frames into rx_line and captures frames from tx_line.
  Assumes bit_clks system clocks per bit and an idle-high line.
*/
`timescale 1ns/10ps
`default_nettype none
module acb_remote_peer (
  // clock
  input wire logic clk_sys,
  // link setup
  input wire logic [11:0] bit_clks, // whole clocks per bit, no rate error
  input wire logic nine,
  // serial lines
  input wire logic tx_line,
  input wire logic tx_line_oe,
  output logic rx_line
);
  logic [8:0] rx_word;
  logic [8:0] w;
  logic rx_stop;
  int rx_count;
  int low_len = 0;
  int run = 0;
  int nb;
  int i;
  // ==========================================================
  // sender: start zero, data lsb first, stop level as asked
  task automatic send(input logic [8:0] d, input logic stop);
    int k;
    int last;
    last = nine ? 10 : 9;
    @(posedge clk_sys);
    for (k = 0; k <= last; k++) begin
      rx_line <= (k == 0) ? 1'b0 : (k == last) ? stop : d[k-1];
      repeat (bit_clks) @(posedge clk_sys);
    end
    rx_line <= 1'b1;
  endtask
  // short low pulse, far under half a bit
  task automatic glitch();
    @(posedge clk_sys);
    rx_line <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rx_line <= 1'b1;
  endtask
  // ==========================================================
  // capture: mid-bit sampling, the ninth bit kept as plain data
  initial begin
    rx_line = 1'b1;
    rx_count = 0;
    forever begin
      @(posedge clk_sys);
      if (tx_line_oe === 1'b1 && tx_line === 1'b0) begin
        nb = nine ? 9 : 8;
        w = '0;
        repeat (bit_clks / 2) @(posedge clk_sys);
        for (i = 0; i <= nb; i++) begin
          repeat (bit_clks) @(posedge clk_sys);
          if (i < nb) begin
            w[i] = tx_line;
          end else begin
            rx_stop = tx_line;
          end
        end
        rx_word = w;
        rx_count++;
      end
    end
  end
  // length of the last low run, used to measure the bit rate
  always @(posedge clk_sys) begin
    if (tx_line === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run != 0) low_len <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

/* dv/acb_serial_test.sv */
/*
  Self-checking bench for acb_serial with a remote peer on the serial lines.
  Assumes the register port answers one cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAIT(c) begin for (wk = 0; wk < 4000 && !(c); wk++) begin @(posedge clk_sys); #1; \
  end if (!(c)) begin num_errors++; complete_run(); end end
module acb_serial_test import acb_pkg::*;;
  logic clk_sys, arst_n, wr_en, rd_en, global_irq_enable, tx_done_ack;
  logic [7:0] addr, wdata, rdata;
  logic irq_rx_done, irq_tx_done, irq_tx_empty, rx_line, tx_line, tx_line_oe;
  logic [11:0] bit_clks;
  logic nine_mode;
  int num_errors, n_compared, wk;
  acb_serial u_acb_serial (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .global_irq_enable(global_irq_enable),
    .tx_done_ack(tx_done_ack), .irq_rx_done(irq_rx_done), .irq_tx_done(irq_tx_done),
    .irq_tx_empty(irq_tx_empty), .rx_line(rx_line), .tx_line(tx_line),
    .tx_line_oe(tx_line_oe));
  acb_remote_peer u_peer (.clk_sys(clk_sys), .bit_clks(bit_clks), .nine(nine_mode),
    .tx_line(tx_line), .tx_line_oe(tx_line_oe), .rx_line(rx_line));
  always #5 clk_sys = ~clk_sys;
  // ==========================================================
  // register port master
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic ack();
    @(posedge clk_sys);
    tx_done_ack <= 1'b1;
    @(posedge clk_sys);
    tx_done_ack <= 1'b0;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rchk(ACB_OFF_CTRL, 8'h00);
    rchk(ACB_OFF_STAT, 8'h20);
    rchk(ACB_OFF_BAUD, 8'h00);
    wr(ACB_OFF_BAUD, 8'hA5);
    rchk(ACB_OFF_BAUD, 8'hA5);
    wr(8'h3F, 8'h5A);
    rchk(8'h3F, 8'h00);
    wr(ACB_OFF_STAT, 8'hBF);
    rchk(ACB_OFF_STAT, 8'h20);
    wr(ACB_OFF_CTRL, 8'hE3);
    rchk(ACB_OFF_CTRL, 8'hE0);
    `CHK(irq_tx_empty, 1'b1)
    @(posedge clk_sys) global_irq_enable <= 1'b0;
    #1;
    `CHK(irq_tx_empty, 1'b0)
    @(posedge clk_sys) global_irq_enable <= 1'b1;
    wr(ACB_OFF_CTRL, 8'h00);
    wr(ACB_OFF_BAUD, 8'h00);
    // the divider reloads only at zero, so the old slow count must run out first
    repeat (170) @(posedge clk_sys);
    $display("test regs finished");
  endtask
  task automatic t_tx();
    wr(ACB_OFF_CTRL, 8'hF8);
    wr(ACB_OFF_DATA, 8'h5A);
    `WAIT(irq_tx_done === 1'b1)
    `CHK(irq_tx_empty, 1'b1)
    `CHK(u_peer.rx_word[7:0], 8'h5A)
    `CHK(u_peer.rx_stop, 1'b1)
    rchk(ACB_OFF_STAT, 8'h60);
    ack();
    rchk(ACB_OFF_STAT, 8'h20);
    // three clocks a tick: 48 clocks a bit; the start bit may be cut by the
    // free-running tick phase, so time the seven zero bits after a one
    wr(ACB_OFF_BAUD, 8'h02);
    bit_clks = 12'd48;
    wr(ACB_OFF_DATA, 8'h01);
    `WAIT(irq_tx_done === 1'b1)
    `CHK(u_peer.low_len, 7 * 48)
    wr(ACB_OFF_STAT, 8'h40);
    rchk(ACB_OFF_STAT, 8'h20);
    wr(ACB_OFF_BAUD, 8'h00);
    bit_clks = 12'd16;
    $display("test tx finished");
  endtask
  task automatic t_rx();
    u_peer.send(9'h0C3, 1'b1);
    `WAIT(irq_rx_done === 1'b1)
    rchk(ACB_OFF_STAT, 8'hA0);
    rchk(ACB_OFF_DATA, 8'hC3);
    rchk(ACB_OFF_STAT, 8'h20);
    u_peer.send(9'h03C, 1'b0);
    `WAIT(irq_rx_done === 1'b1)
    rchk(ACB_OFF_STAT, 8'hB0);
    rchk(ACB_OFF_DATA, 8'h3C);
    u_peer.send(9'h081, 1'b1);
    `WAIT(irq_rx_done === 1'b1)
    rchk(ACB_OFF_STAT, 8'hA0);
    rchk(ACB_OFF_DATA, 8'h81);
    u_peer.glitch();
    repeat (200) @(posedge clk_sys);
    `CHK(irq_rx_done, 1'b0)
    $display("test rx finished");
  endtask
  task automatic t_overrun();
    u_peer.send(9'h011, 1'b1);
    u_peer.send(9'h022, 1'b1);
    rchk(ACB_OFF_STAT, 8'hA0);
    rchk(ACB_OFF_DATA, 8'h11);
    rchk(ACB_OFF_STAT, 8'h28);
    u_peer.send(9'h033, 1'b1);
    `WAIT(irq_rx_done === 1'b1)
    rchk(ACB_OFF_STAT, 8'hA0);
    rchk(ACB_OFF_DATA, 8'h33);
    $display("test overrun finished");
  endtask
  task automatic t_nine();
    nine_mode = 1'b1;
    wr(ACB_OFF_CTRL, 8'hDD);
    rchk(ACB_OFF_CTRL, 8'hDC);
    wr(ACB_OFF_DATA, 8'hA5);
    `WAIT(irq_tx_done === 1'b1)
    `CHK(u_peer.rx_word, 9'h1A5)
    ack();
    u_peer.send(9'h1F0, 1'b1);
    `WAIT(irq_rx_done === 1'b1)
    rchk(ACB_OFF_CTRL, 8'hDE);
    rchk(ACB_OFF_DATA, 8'hF0);
    wr(ACB_OFF_CTRL, 8'hD8);
    nine_mode = 1'b0;
    $display("test nine finished");
  endtask
  task automatic t_rx_off();
    int n;
    u_peer.send(9'h000, 1'b0);
    `WAIT(irq_rx_done === 1'b1)
    rchk(ACB_OFF_DATA, 8'h00);
    rchk(ACB_OFF_STAT, 8'h30);
    wr(ACB_OFF_CTRL, 8'hC8);
    rchk(ACB_OFF_STAT, 8'h30);
    n = u_peer.rx_count;
    wr(ACB_OFF_DATA, 8'h77);
    `WAIT(u_peer.rx_count == n + 1)
    repeat (40) @(posedge clk_sys);
    u_peer.send(9'h055, 1'b1);
    rchk(ACB_OFF_STAT, 8'h30);
    wr(ACB_OFF_CTRL, 8'hD8);
    u_peer.send(9'h055, 1'b1);
    `WAIT(irq_rx_done === 1'b1)
    rchk(ACB_OFF_STAT, 8'hA0);
    rchk(ACB_OFF_DATA, 8'h55);
    $display("test receiver off finished");
  endtask
  task automatic t_tx_off();
    int n;
    n = u_peer.rx_count;
    wr(ACB_OFF_DATA, 8'h11);
    wr(ACB_OFF_DATA, 8'h22);
    wr(ACB_OFF_CTRL, 8'hD0);
    `WAIT(u_peer.rx_count == n + 2)
    `CHK(u_peer.rx_word[7:0], 8'h22)
    `WAIT(irq_tx_done === 1'b1)
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(tx_line_oe, 1'b0)
    ack();
    wr(ACB_OFF_DATA, 8'h33);
    repeat (400) @(posedge clk_sys);
    `CHK(u_peer.rx_count, n + 2)
    wr(ACB_OFF_CTRL, 8'hD8);
    `WAIT(u_peer.rx_count == n + 3)
    `CHK(u_peer.rx_word[7:0], 8'h33)
    $display("test transmitter off finished");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    global_irq_enable = 1'b1;
    tx_done_ack = 1'b0;
    bit_clks = 12'd16;
    nine_mode = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_overrun();
    t_nine();
    t_rx_off();
    t_tx_off();
    complete_run();
  end
endmodule
`default_nettype wire
